/* File: core/sixio_port.v */
// Sixteen-pin general-purpose I/O port with direction, latch and pin-state sets
//
// Operation
// - Make-input command clears only the selected pin's direction bit.
// - Reset clears every direction bit; all pins start as inputs.
// - Writing zeros to direction bits makes those pins inputs, many at once.
// - Pin-state bit of an input pin returns the external level.
// - Latch writes to input pins are stored but do not drive the pin.
// - Input-to-output change drives the pin with the stored latch value.
// - Pin-state bit of an output pin reflects its latch bit.
// - Pulse-measure and serial-receive use clears direction bit and leaves it cleared.
// - Driver enabled only while direction bit is one; level equals latch bit.
// - Drive-high sets direction and latch bits of selected pin together.
// - Drive-low sets direction bit and clears latch bit together.
`timescale 1ns/1ps
`include "sixio_consts.vh"

module sixio_port (
    input  wire        core_clk,
    input  wire        reset_n,
    input  wire [2:0]  pin_cmd,
    input  wire [3:0]  pin_sel,
    input  wire        dir_wr,
    input  wire [15:0] dir_wdata,
    input  wire [15:0] dir_wmask,
    input  wire        lat_wr,
    input  wire [15:0] lat_wdata,
    input  wire [15:0] lat_wmask,
    input  wire [15:0] pin_in,
    output wire [15:0] pin_out,
    output wire [15:0] pin_oe,
    output wire [15:0] dir_bits,
    output wire [15:0] latch_bits,
    output wire [15:0] pin_state_bits
);

    reg [15:0] dir_q;
    reg [15:0] dir_d;
    reg [15:0] lat_q;
    reg [15:0] lat_d;
    reg [15:0] sync1_q;
    reg [15:0] sync2_q;
    reg [15:0] state_q;
    reg [15:0] out_q;
    reg [15:0] oe_q;
    wire [15:0] sel_mask;

    // One-hot of the selected pin
    function [15:0] sixio_onehot;
        input [3:0] idx;
        begin
            sixio_onehot = 16'h0001 << idx;
        end
    endfunction

    assign sel_mask = sixio_onehot(pin_sel);

    ////////////////////////////////////////////////////////////////////
    // Next direction and latch values
    always @*
    begin
        dir_d = dir_q;
        lat_d = lat_q;
        if (dir_wr)
            dir_d = (dir_q & ~dir_wmask) | (dir_wdata & dir_wmask);
        if (lat_wr)
            lat_d = (lat_q & ~lat_wmask) | (lat_wdata & lat_wmask);
        case (pin_cmd)
            `SIXIO_CMD_INPUT:
                dir_d = dir_d & ~sel_mask;
            `SIXIO_CMD_CAPTURE:
                dir_d = dir_d & ~sel_mask;
            `SIXIO_CMD_OUTPUT:
                dir_d = dir_d | sel_mask;
            `SIXIO_CMD_HIGH:
            begin
                dir_d = dir_d | sel_mask;
                lat_d = lat_d | sel_mask;
            end
            `SIXIO_CMD_LOW:
            begin
                dir_d = dir_d | sel_mask;
                lat_d = lat_d & ~sel_mask;
            end
            default:
            begin
                dir_d = dir_d;
                lat_d = lat_d;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Registers, synchroniser and pin drivers
    always @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            dir_q   <= `SIXIO_DIR_RESET;
            lat_q   <= `SIXIO_LAT_RESET;
            sync1_q <= 16'h0000;
            sync2_q <= 16'h0000;
            state_q <= 16'h0000;
            out_q   <= 16'h0000;
            oe_q    <= 16'h0000;
        end
        else
        begin
            dir_q   <= dir_d;
            lat_q   <= lat_d;
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            state_q <= (dir_d & lat_d) | (~dir_d & sync2_q);
            oe_q    <= dir_d;
            out_q   <= lat_d & dir_d;
        end
    end

    assign pin_out        = out_q;
    assign pin_oe         = oe_q;
    assign dir_bits       = dir_q;
    assign latch_bits     = lat_q;
    assign pin_state_bits = state_q;

endmodule // sixio_port

/* File: core/sixio_consts.vh */
// Constants for the sixteen-pin I/O port
`ifndef SIXIO_CONSTS_VH
`define SIXIO_CONSTS_VH
`define SIXIO_WIDTH       16
`define SIXIO_DIR_RESET   16'h0000
`define SIXIO_LAT_RESET   16'h0000
`define SIXIO_CMD_NONE    3'h0
`define SIXIO_CMD_INPUT   3'h1
`define SIXIO_CMD_HIGH    3'h2
`define SIXIO_CMD_LOW     3'h3
`define SIXIO_CMD_OUTPUT  3'h4
`define SIXIO_CMD_CAPTURE 3'h5
`endif

/* File: verif/sixio_ext_model.sv */
// Pull-up pin model
`timescale 1ns/1ps
module sixio_ext (
    input  wire [15:0] pin_out,
    input  wire [15:0] pin_oe,
    output wire [15:0] pin_in
);
    assign pin_in = (pin_oe & pin_out) | ~pin_oe;
endmodule // sixio_ext

/* File: verif/sixio_chk_assertions.sv */
// Port checker
`timescale 1ns/1ps
module sixio_chk (
    input wire core_clk, reset_n, dir_wr, lat_wr,
    input wire [2:0] pin_cmd,
    input wire [3:0] pin_sel,
    input wire [15:0] pin_in, pin_out, pin_oe, dir_bits, latch_bits, pin_state_bits
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    a_rst: assert property (disable iff (1'b0) !reset_n |=> dir_bits == 16'h0000)
        else $error("rst");
    a_oe: assert property (pin_oe == dir_bits) else $error("oe");
    a_out: assert property (pin_out == (latch_bits & dir_bits)) else $error("out");
    a_st: assert property ((pin_state_bits & dir_bits) == (latch_bits & dir_bits))
        else $error("st");
    a_hi: assert property (pin_cmd == 3'h2 |=>
        dir_bits[$past(pin_sel)] && latch_bits[$past(pin_sel)]) else $error("hi");
    a_lo: assert property (pin_cmd == 3'h3 |=>
        dir_bits[$past(pin_sel)] && !latch_bits[$past(pin_sel)]) else $error("lo");
    a_in: assert property (pin_cmd == 3'h1 && !dir_wr && !lat_wr |=> $stable(latch_bits) &&
        dir_bits == ($past(dir_bits) & ~(16'h0001 << $past(pin_sel)))) else $error("in");
    a_syn: assert property ((dir_bits == 16'h0000)[*4] |->
        pin_state_bits == $past(pin_in, 3)) else $error("syn");
endmodule // sixio_chk
bind sixio_port sixio_chk u_chk (.*);

/* File: verif/test_sixteen_pin_io_port.sv */
// Bench for the I/O port
`timescale 1ns/1ps
module test_sixteen_pin_io_port;
    logic core_clk = 0, reset_n = 0, dir_wr = 0, lat_wr = 0;
    logic [2:0] pin_cmd = 3'h0;
    logic [3:0] pin_sel = 4'h0;
    logic [15:0] dir_wdata = '0, dir_wmask = '0, lat_wdata = '0, lat_wmask = '0;
    wire [15:0] pin_in, pin_out, pin_oe, dir_bits, latch_bits, pin_state_bits;
    int fails = 0, tests_run = 0, cyc = 0;
    sixio_port DUT (.*);
    sixio_ext u_ext (.*);
    initial forever #4 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin fails++; end_sim; end
    end
    task end_sim;
        $display("tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input string n, input logic [15:0] e, g);
        tests_run++;
        if (g !== e) begin fails++; $display("ERROR %s exp %h got %h", n, e, g); end
    endtask
    task op(input [2:0] c, input [3:0] s, input dw, lw, input [15:0] m, d);
        @(posedge core_clk);
        pin_cmd <= c; pin_sel <= s; dir_wr <= dw; lat_wr <= lw;
        dir_wmask <= m; lat_wmask <= m; dir_wdata <= d; lat_wdata <= d;
        @(posedge core_clk);
        pin_cmd <= 3'h0; dir_wr <= 0; lat_wr <= 0;
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    task t_cmds;
        chk("dir", 16'h0000, dir_bits);
        op(3'h2, 4'h4, 0, 0, '0, '0);
        chk("dir", 16'h0010, dir_bits);
        chk("lat", 16'h0010, latch_bits);
        op(3'h3, 4'h5, 0, 0, '0, '0);
        chk("out", 16'h0010, pin_out);
        op(3'h1, 4'h4, 0, 0, '0, '0);
        chk("dir", 16'h0020, dir_bits);
        chk("lat", 16'h0010, latch_bits);
        op(3'h5, 4'h5, 0, 0, '0, '0);
        chk("dir", 16'h0000, dir_bits);
    endtask
    task t_latch;
        op(3'h0, 4'h0, 0, 1, 16'h0080, 16'h0080);
        chk("lat", 16'h0090, latch_bits);
        chk("out", 16'h0000, pin_out);
        op(3'h0, 4'h0, 0, 1, 16'h0080, '0);
        chk("lat", 16'h0010, latch_bits);
        chk("out", 16'h0000, pin_out);
        chk("state", 16'hFFFF, pin_state_bits);
        op(3'h4, 4'h7, 0, 0, '0, '0);
        chk("state", 16'hFF7F, pin_state_bits);
        chk("oe", 16'h0080, pin_oe);
        chk("out", 16'h0000, pin_out);
        op(3'h0, 4'h0, 1, 0, 16'h0090, '0);
        chk("dir", 16'h0000, dir_bits);
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        reset_n <= 1;
        t_cmds;
        t_latch;
        end_sim;
    end
endmodule // test_sixteen_pin_io_port
